/* pkg/bwc_pkg.sv */
package bwc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W  = 4;
  localparam int MODE_W = 2;
  // default sizes of the channel datapath
  localparam int NUM_CH_DEF    = 8;
  localparam int PIX_W_DEF     = 12;
  localparam int OFS_W_DEF     = 12;
  localparam int GAIN_W_DEF    = 16;
  localparam int BL_TARGET_DEF = 64;
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_GAIN_BAL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BL_SEL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BL_VAL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BL_AUTO  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BL_BAL   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WC_SEL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WC_VAL   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_GAIN_SEL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_GAIN_VAL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h24;
  // status register field positions
  localparam int ST_GBAL_ACT = 0;
  localparam int ST_BBAL_ACT = 1;
  localparam int ST_AUTO_ACT = 2;
  localparam int ST_GBAL_EQ  = 3;
  localparam int ST_BBAL_EQ  = 4;
  // automatic mode codes; 2'h3 is kept for device-defined modes
  typedef logic [MODE_W-1:0] auto_mode_t;
  localparam auto_mode_t MODE_OFF  = 2'h0;
  localparam auto_mode_t MODE_ONCE = 2'h1;
  localparam auto_mode_t MODE_CONT = 2'h2;
  // channel selector codes; taps follow from SEL_TAP1 upward
  localparam logic [SEL_W-1:0] SEL_ALL  = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RED  = 4'h1;
  localparam logic [SEL_W-1:0] SEL_TAP1 = 4'h7;
  // reset values
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [DATA_W-1:0] BL_RST = 32'h0;
  localparam logic [DATA_W-1:0] WC_RST = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] GAIN_RST = 32'h00000100;
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
endpackage

/* hw/auto_mode_ctrl.sv */
`timescale 1ns/1ps
module auto_mode_ctrl
  import bwc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wr_i,
  input  wire auto_mode_t  wdata_i,
  input  wire logic        converged_i,
  output auto_mode_t       mode_o,
  output logic             active_o
);
  auto_mode_t mode_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_OFF;
    end else if (ce_i) begin
      // (R3) (R11) (R15) once clears itself
      if (wr_i) begin
        mode_q <= wdata_i;
      end else if (mode_q == MODE_ONCE && converged_i) begin
        mode_q <= MODE_OFF;
      end
    end
  end

  // reserved codes are stored and read back but run nothing
  assign active_o = (mode_q == MODE_ONCE) || (mode_q == MODE_CONT);
  assign mode_o   = mode_q;

  property p_once_ends;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !wr_i && mode_q == MODE_ONCE && converged_i)
      |=> (mode_q == MODE_OFF);
  endproperty
  a_once_ends: assert property (p_once_ends) // (R3)
    else $error("once mode did not return to off");

  property p_cont_holds;
    @(posedge clk_i) disable iff (rst_i)
    (!wr_i && mode_q == MODE_CONT) |=> (mode_q == MODE_CONT);
  endproperty
  a_cont_holds: assert property (p_cont_holds) // (R4)
    else $error("continuous mode left without a write");
endmodule

/* hw/video_channel_path.sv */
`timescale 1ns/1ps
module video_channel_path
  import bwc_pkg::*;
#(
  parameter int PIX_W = PIX_W_DEF
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    valid_i,
  input  wire logic [PIX_W-1:0]        pix_i,
  input  wire logic signed [PIX_W+1:0] ofs_i,
  input  wire logic [PIX_W-1:0]        ceil_i,
  output logic [PIX_W-1:0]             pix_o
);
  logic signed [PIX_W+2:0] sum;

  assign sum = $signed({3'b000, pix_i}) + {ofs_i[PIX_W+1], ofs_i};

  // dc offset then saturation at the ceiling, never wrapping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_o <= '0;
    end else if (ce_i && valid_i) begin
      if (sum < 0) begin
        pix_o <= '0;
      end else if (sum > $signed({3'b000, ceil_i})) begin
        pix_o <= ceil_i;
      end else begin
        pix_o <= sum[PIX_W-1:0];
      end
    end
  end

  property p_clip;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && valid_i) |=> (pix_o <= $past(ceil_i));
  endproperty
  a_clip: assert property (p_clip) // (R19)
    else $error("pixel above saturation ceiling");
endmodule

/* hw/black_level_white_clip_ctrl.sv */
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
// Contract
// (R1) gain tap balancing mode matches all channel gains when automatic.
// (R2) balancing off leaves each gain exactly as software wrote it.
// (R3) once mode balances gains, then sets its mode back to off.
// (R4) continuous mode keeps balancing gains until the mode changes.
// (R5) every auto mode supports off, once and continuous; extras allowed.
// (R6) black offset selector picks all, colour, luma/chroma or tap.
// (R7) the all black offset is its own common stage.
// (R8) selected black offset adds as dc offset to its channel.
// (R9) black offset auto mode exists per selected channel.
// (R10) auto off uses only the software black offset value.
// (R11) auto once adjusts black offset, then returns to off.
// (R12) auto continuous keeps adjusting the black offset.
// (R13) black balancing matches black offsets of all channels.
// (R14) black balancing off leaves offsets under software control.
// (R15) black balancing once matches, then returns to off.
// (R16) black balancing continuous keeps matching offsets.
// (R17) saturation selector picks all, colour, luma/chroma or tap.
// (R18) the all saturation ceiling is its own common stage.
// (R19) each channel saturates at its ceiling, never exceeding it.
// (R20) values under automatic adjustment read back as in use.
// (R21) auto modes are two-bit codes; spare codes device-defined.
module black_level_white_clip_ctrl
  import bwc_pkg::*;
#(
  parameter int NCH       = NUM_CH_DEF,
  parameter int PIX_W     = PIX_W_DEF,
  parameter int OFS_W     = OFS_W_DEF,
  parameter int GAIN_W    = GAIN_W_DEF,
  parameter int BL_TARGET = BL_TARGET_DEF
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire reg_req_t                  req_i,
  output logic [DATA_W-1:0]              rdata_o,
  input  wire logic                      vid_valid_i,
  input  wire logic                      vid_dark_i,
  input  wire logic [NCH-1:0][PIX_W-1:0] vid_i,
  output logic                           vid_valid_o,
  output logic [NCH-1:0][PIX_W-1:0]      vid_o
);
  localparam int SW = PIX_W + 2;
  localparam logic signed [OFS_W-1:0] OMAX = {1'b0, {(OFS_W-1){1'b1}}};
  localparam logic signed [OFS_W-1:0] OMIN = {1'b1, {(OFS_W-1){1'b0}}};
  localparam logic signed [SW-1:0] TGT = SW'(BL_TARGET);

  // index 0 is the common all stage, 1..NCH the channels
  logic signed [OFS_W-1:0] bl_q   [0:NCH];
  logic [PIX_W-1:0]        wc_q   [0:NCH];
  logic [GAIN_W-1:0]       gain_q [0:NCH];
  logic [SEL_W-1:0]        bl_sel_q;
  logic [SEL_W-1:0]        wc_sel_q;
  logic [SEL_W-1:0]        gain_sel_q;
  logic signed [SW-1:0]    dsum   [0:NCH];
  auto_mode_t              bl_mode [0:NCH];
  logic [NCH:0]            bl_act;
  logic [NCH:0]            bl_conv;
  auto_mode_t              gbal_mode;
  auto_mode_t              bbal_mode;
  logic                    gbal_act;
  logic                    bbal_act;
  logic                    gbal_eq;
  logic                    bbal_eq;
  logic                    dark_smp;
  logic                    wr;
  logic                    w_gbal;
  logic                    w_bsel;
  logic                    w_bval;
  logic                    w_baut;
  logic                    w_bbal;
  logic                    w_wsel;
  logic                    w_wval;
  logic                    w_gsel;
  logic                    w_gval;
  logic [DATA_W-1:0]       rd_word;
  function automatic logic signed [SW-1:0] sx(
    input logic signed [OFS_W-1:0] v);
    sx = {{(SW-OFS_W){v[OFS_W-1]}}, v};
  endfunction
  function automatic logic sel_ok(input logic [SEL_W-1:0] s);
    sel_ok = (32'(s) <= NCH);
  endfunction
  assign wr       = req_i.wr && ce_i;
  assign dark_smp = vid_valid_i && vid_dark_i;
  always_comb begin
    w_gbal = 1'b0;
    w_bsel = 1'b0;
    w_bval = 1'b0;
    w_baut = 1'b0;
    w_bbal = 1'b0;
    w_wsel = 1'b0;
    w_wval = 1'b0;
    w_gsel = 1'b0;
    w_gval = 1'b0;
    if (!wr) begin
      w_gbal = 1'b0;
    end else if (req_i.addr == OFS_GAIN_BAL) begin
      w_gbal = 1'b1;
    end else if (req_i.addr == OFS_BL_SEL) begin
      w_bsel = 1'b1;
    end else if (req_i.addr == OFS_BL_VAL) begin
      w_bval = sel_ok(bl_sel_q);
    end else if (req_i.addr == OFS_BL_AUTO) begin
      w_baut = sel_ok(bl_sel_q);
    end else if (req_i.addr == OFS_BL_BAL) begin
      w_bbal = 1'b1;
    end else if (req_i.addr == OFS_WC_SEL) begin
      w_wsel = 1'b1;
    end else if (req_i.addr == OFS_WC_VAL) begin
      w_wval = sel_ok(wc_sel_q);
    end else if (req_i.addr == OFS_GAIN_SEL) begin
      w_gsel = 1'b1;
    end else if (req_i.addr == OFS_GAIN_VAL) begin
      w_gval = sel_ok(gain_sel_q);
    end
  end
  // (R6) (R17) selectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bl_sel_q   <= SEL_RST;
      wc_sel_q   <= SEL_RST;
      gain_sel_q <= SEL_RST;
    end else begin
      if (w_bsel && sel_ok(req_i.wdata[SEL_W-1:0])) begin
        bl_sel_q <= req_i.wdata[SEL_W-1:0];
      end
      if (w_wsel && sel_ok(req_i.wdata[SEL_W-1:0])) begin
        wc_sel_q <= req_i.wdata[SEL_W-1:0];
      end
      if (w_gsel && sel_ok(req_i.wdata[SEL_W-1:0])) begin
        gain_sel_q <= req_i.wdata[SEL_W-1:0];
      end
    end
  end
  // black level seen on dark pixels, all stage plus channel stage
  always_comb begin
    for (int c = 1; c <= NCH; c++) begin
      dsum[c] = $signed({2'b00, vid_i[c-1]}) + sx(bl_q[0]) + sx(bl_q[c]);
    end
    dsum[0] = dsum[1];
  end
  // (R13) (R1) matched when every channel equals channel one
  always_comb begin
    gbal_eq = 1'b1;
    bbal_eq = 1'b1;
    for (int c = 2; c <= NCH; c++) begin
      if (gain_q[c] != gain_q[1]) begin
        gbal_eq = 1'b0;
      end
      if (bl_q[c] != bl_q[1]) begin
        bbal_eq = 1'b0;
      end
    end
  end
  // (R5) (R21) one mode field per automatic function
  auto_mode_ctrl u_gbal (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .wr_i        (w_gbal),
    .wdata_i     (req_i.wdata[MODE_W-1:0]),
    .converged_i (gbal_eq),
    .mode_o      (gbal_mode),
    .active_o    (gbal_act)
  );
  auto_mode_ctrl u_bbal (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .wr_i        (w_bbal),
    .wdata_i     (req_i.wdata[MODE_W-1:0]),
    .converged_i (bbal_eq),
    .mode_o      (bbal_mode),
    .active_o    (bbal_act)
  );
  // (R9) auto mode held per selectable channel, all stage included
  for (genvar g = 0; g <= NCH; g++) begin : g_auto
    assign bl_conv[g] = dark_smp && ((dsum[g] == TGT)
      || (dsum[g] < TGT && bl_q[g] == OMAX)
      || (dsum[g] > TGT && bl_q[g] == OMIN));
    auto_mode_ctrl u_auto (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .wr_i        (w_baut && bl_sel_q == SEL_W'(g)),
      .wdata_i     (req_i.wdata[MODE_W-1:0]),
      .converged_i (bl_conv[g]),
      .mode_o      (bl_mode[g]),
      .active_o    (bl_act[g])
    );
  end
  // (R7) (R8) black offsets: software, auto step, then balancing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c <= NCH; c++) begin
        bl_q[c] <= BL_RST[OFS_W-1:0];
      end
    end else if (ce_i) begin
      for (int c = 0; c <= NCH; c++) begin
        // (R10) (R14) software value first
        if (w_bval && bl_sel_q == SEL_W'(c)) begin
          bl_q[c] <= req_i.wdata[OFS_W-1:0];
        // (R11) (R12) auto step toward the dark target
        end else if (bl_act[c] && dark_smp && !bl_conv[c]) begin
          bl_q[c] <= (dsum[c] < TGT) ? bl_q[c] + 1'b1 : bl_q[c] - 1'b1;
        // (R15) (R16) balancing step toward channel one
        end else if (bbal_act && c >= 2 && bl_q[c] != bl_q[1]) begin
          bl_q[c] <= (bl_q[c] < bl_q[1]) ? bl_q[c] + 1'b1
                                          : bl_q[c] - 1'b1;
        end
      end
    end
  end
  // (R2) gains move only on writes or while balancing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c <= NCH; c++) begin
        gain_q[c] <= GAIN_RST[GAIN_W-1:0];
      end
    end else if (ce_i) begin
      for (int c = 0; c <= NCH; c++) begin
        if (w_gval && gain_sel_q == SEL_W'(c)) begin
          gain_q[c] <= req_i.wdata[GAIN_W-1:0];
        // (R1) (R4) balancing step toward channel one
        end else if (gbal_act && c >= 2 && gain_q[c] != gain_q[1]) begin
          gain_q[c] <= (gain_q[c] < gain_q[1]) ? gain_q[c] + 1'b1
                                              : gain_q[c] - 1'b1;
        end
      end
    end
  end
  // (R18) ceilings, all stage held apart from the channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c <= NCH; c++) begin
        wc_q[c] <= WC_RST[PIX_W-1:0];
      end
    end else if (w_wval) begin
      for (int c = 0; c <= NCH; c++) begin
        if (wc_sel_q == SEL_W'(c)) begin
          wc_q[c] <= req_i.wdata[PIX_W-1:0];
        end
      end
    end
  end
  // (R8) (R19) per-channel offset and clip
  for (genvar g = 1; g <= NCH; g++) begin : g_path
    video_channel_path #(
      .PIX_W (PIX_W)
    ) u_path (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .valid_i (vid_valid_i),
      .pix_i   (vid_i[g-1]),
      .ofs_i   (sx(bl_q[0]) + sx(bl_q[g])),
      .ceil_i  ((wc_q[0] < wc_q[g]) ? wc_q[0] : wc_q[g]),
      .pix_o   (vid_o[g-1])
    );
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_valid_o <= 1'b0;
    end else if (ce_i) begin
      vid_valid_o <= vid_valid_i;
    end
  end
  // (R20) reads show live values, including auto adjustments
  always_comb begin
    rd_word = '0;
    if (req_i.addr == OFS_GAIN_BAL) begin
      rd_word = DATA_W'(gbal_mode);
    end else if (req_i.addr == OFS_BL_SEL) begin
      rd_word = DATA_W'(bl_sel_q);
    end else if (req_i.addr == OFS_BL_VAL) begin
      if (sel_ok(bl_sel_q)) begin
        rd_word = DATA_W'(sx(bl_q[bl_sel_q]));
        rd_word[DATA_W-1:SW] = {(DATA_W-SW){bl_q[bl_sel_q][OFS_W-1]}};
      end
    end else if (req_i.addr == OFS_BL_AUTO) begin
      if (sel_ok(bl_sel_q)) begin
        rd_word = DATA_W'(bl_mode[bl_sel_q]);
      end
    end else if (req_i.addr == OFS_BL_BAL) begin
      rd_word = DATA_W'(bbal_mode);
    end else if (req_i.addr == OFS_WC_SEL) begin
      rd_word = DATA_W'(wc_sel_q);
    end else if (req_i.addr == OFS_WC_VAL) begin
      if (sel_ok(wc_sel_q)) begin
        rd_word = DATA_W'(wc_q[wc_sel_q]);
      end
    end else if (req_i.addr == OFS_GAIN_SEL) begin
      rd_word = DATA_W'(gain_sel_q);
    end else if (req_i.addr == OFS_GAIN_VAL) begin
      if (sel_ok(gain_sel_q)) begin
        rd_word = DATA_W'(gain_q[gain_sel_q]);
      end
    end else if (req_i.addr == OFS_STATUS) begin
      rd_word[ST_GBAL_ACT] = gbal_act;
      rd_word[ST_BBAL_ACT] = bbal_act;
      rd_word[ST_AUTO_ACT] = |bl_act;
      rd_word[ST_GBAL_EQ]  = gbal_eq;
      rd_word[ST_BBAL_EQ]  = bbal_eq;
    end
  end
  // read data stands for one enabled cycle after the strobe, held while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= req_i.rd ? rd_word : '0;
    end
  end
  property p_gain_off;
    @(posedge clk_i) disable iff (rst_i)
    (!gbal_act && !w_gval) |=> $stable(gain_q[2]);
  endproperty
  a_gain_off: assert property (p_gain_off) // (R2)
    else $error("gain moved while balancing off");
  property p_gain_step;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && gbal_act && !w_gval && gain_q[2] < gain_q[1])
      |=> (gain_q[2] == $past(gain_q[2]) + 1'b1);
  endproperty
  a_gain_step: assert property (p_gain_step) // (R1)
    else $error("gain balancing did not step up");
  property p_bl_sel;
    @(posedge clk_i) disable iff (rst_i)
    (w_bsel && req_i.wdata[SEL_W-1:0] == SEL_RED)
      |=> (bl_sel_q == SEL_RED);
  endproperty
  a_bl_sel: assert property (p_bl_sel) // (R6)
    else $error("black selector not taken");
  property p_all_apart;
    @(posedge clk_i) disable iff (rst_i)
    (w_bval && bl_sel_q == SEL_ALL && !bl_act[1] && !bbal_act)
      |=> $stable(bl_q[1]);
  endproperty
  a_all_apart: assert property (p_all_apart) // (R7)
    else $error("all stage write touched a channel");
  property p_auto_off;
    @(posedge clk_i) disable iff (rst_i)
    (bl_mode[1] == MODE_OFF && !bbal_act && !w_bval) |=> $stable(bl_q[1]);
  endproperty
  a_auto_off: assert property (p_auto_off) // (R10)
    else $error("black offset moved with auto off");
  property p_bbal_step;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bbal_act && !bl_act[2] && !w_bval && bl_q[2] > bl_q[1])
      |=> (bl_q[2] == $past(bl_q[2]) - 1'b1);
  endproperty
  a_bbal_step: assert property (p_bbal_step) // (R16)
    else $error("black balancing did not step down");
  property p_rd_data;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && req_i.rd) |=> (rdata_o == $past(rd_word));
  endproperty
  a_rd_data: assert property (p_rd_data) // (R20)
    else $error("read data not the live value");
  property p_rd_only_once;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !req_i.rd) |=> (rdata_o == '0);
  endproperty
  a_rd_only_once: assert property (p_rd_only_once) // (R20)
    else $error("read data held past its cycle");
endmodule

/* tb/black_level_white_clip_ctrl_tb_top.sv */
`timescale 1ns/1ps
module black_level_white_clip_ctrl_tb_top;
  import bwc_pkg::*;
  localparam int NCH = 8;
  localparam int PW  = 12;
  localparam int VW  = NCH * PW;

  logic                   clk_i       = 1'b0;
  logic                   rst_i       = 1'b1;
  logic                   ce_i        = 1'b1;
  reg_req_t               req_i       = '0;
  logic [DATA_W-1:0]      rdata_o;
  logic                   vid_valid_i = 1'b0;
  logic                   vid_dark_i  = 1'b0;
  logic [NCH-1:0][PW-1:0] vid_i       = '0;
  logic                   vid_valid_o;
  logic [NCH-1:0][PW-1:0] vid_o;
  int                     errors      = 0;
  int                     tests_run   = 0;
  int                     cycles      = 0;
  logic [DATA_W:0]        rd_q[$];
  logic [VW:0]            vid_q[$];
  logic [DATA_W:0]        rn;
  logic [VW:0]            vn;
  logic                   rd_d        = 1'b0;
  logic [DATA_W-1:0]      seen        = '0;
  logic [31:0]            rnd         = 32'd85804;
  int                     bl_all;
  int                     wc_all;
  int                     bl_ch[NCH];
  int                     wc_ch[NCH];
  auto_mode_t             codes[3]    = '{2'h3, MODE_CONT, MODE_OFF};
  logic [ADDR_W-1:0]      maddr[3]    =
    '{OFS_GAIN_BAL, OFS_BL_AUTO, OFS_BL_BAL};

  always #2 clk_i = ~clk_i;

  black_level_white_clip_ctrl #(.NCH(NCH), .PIX_W(PW)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
    .rdata_o(rdata_o), .vid_valid_i(vid_valid_i), .vid_dark_i(vid_dark_i),
    .vid_i(vid_i), .vid_valid_o(vid_valid_o), .vid_o(vid_o));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [PW-1:0] pexp(input int x, input int k);
    int s;
    int c;
    s = x + bl_all + bl_ch[k];
    c = (wc_ch[k] < wc_all) ? wc_ch[k] : wc_all;
    if (s < 0) s = 0;
    if (s > c) s = c;
    return s[PW-1:0];
  endfunction

  function automatic logic [VW-1:0] one_ch(input int k, input int p);
    logic [VW-1:0] v;
    v = '0;
    v[k*PW +: PW] = p[PW-1:0];
    return v;
  endfunction

  task automatic chk(input string nm, input logic [VW-1:0] e,
                     input logic [VW-1:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
  endtask

  // the note is queued as the strobe goes out; the monitor pops it
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input bit c = 1'b1);
    @(posedge clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    rd_q.push_back({c, e});
    @(posedge clk_i);
    req_i <= '0;
  endtask

  task automatic poll(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                      input int n);
    for (int i = 0; i < n; i++) begin
      rd(a, '0, 1'b0);
      @(posedge clk_i);
      if (seen === e) break;
    end
    chk("polled register", VW'(e), VW'(seen));
  endtask

  task automatic beat(input logic [VW-1:0] x, input bit dk, input bit c);
    logic [VW-1:0] e;
    for (int k = 0; k < NCH; k++) begin
      e[k*PW +: PW] = pexp(int'(x[k*PW +: PW]), k);
    end
    @(posedge clk_i);
    vid_valid_i <= 1'b1;
    vid_dark_i <= dk;
    vid_i <= x;
    vid_q.push_back({c, e});
  endtask

  task automatic idle;
    @(posedge clk_i);
    vid_valid_i <= 1'b0;
  endtask

  always @(posedge clk_i) rd_d <= req_i.rd & ~rst_i;

  // results appear settled at the falling edge
  always @(negedge clk_i) begin
    if (rd_d) begin
      rn = rd_q.pop_front();
      seen = rdata_o;
      if (rn[DATA_W]) chk("rdata_o", {{(VW-DATA_W){1'b0}}, rn[DATA_W-1:0]},
                          {{(VW-DATA_W){1'b0}}, rdata_o});
    end
    if (vid_valid_o === 1'b1) begin
      if (vid_q.size() == 0) begin
        chk("vid_valid_o", '0, '1);
      end else begin
        vn = vid_q.pop_front();
        if (vn[VW]) chk("vid_o", vn[VW-1:0], vid_o);
      end
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    for (int k = 0; k < NCH; k++) begin
      bl_ch[k] = 0;
      wc_ch[k] = 4095;
    end
    bl_all = 0;
    wc_all = 4095;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_GAIN_BAL, 32'h0);
    rd(OFS_BL_SEL, {28'h0, SEL_RST});
    rd(OFS_BL_VAL, BL_RST);
    rd(OFS_BL_AUTO, 32'h0);
    rd(OFS_BL_BAL, 32'h0);
    rd(OFS_WC_SEL, {28'h0, SEL_RST});
    rd(OFS_WC_VAL, 32'h00000FFF);
    rd(OFS_GAIN_VAL, GAIN_RST);
    rd(OFS_STATUS, 32'h00000018);
    rd(8'h40, 32'h0);
    $display("test reset values done");
    foreach (codes[i])
      foreach (maddr[j]) begin
        wr(maddr[j], {30'h0, codes[i]});
        rd(maddr[j], {30'h0, codes[i]});
      end
    wr(OFS_BL_SEL, 32'h9);
    rd(OFS_BL_SEL, 32'h0);
    wr(OFS_WC_SEL, 32'h8);
    rd(OFS_WC_SEL, 32'h8);
    $display("test mode codes and selectors done");
    wr(OFS_BL_SEL, 32'h0);
    wr(OFS_BL_VAL, 32'h5);
    bl_all = 5;
    wr(OFS_BL_SEL, 32'h1);
    wr(OFS_BL_VAL, 32'hFFFFFFE0);
    bl_ch[0] = -32;
    rd(OFS_BL_VAL, 32'hFFFFFFE0);
    wr(OFS_WC_SEL, 32'h0);
    wr(OFS_WC_VAL, 32'hF00);
    wc_all = 'hF00;
    wr(OFS_WC_SEL, 32'h3);
    wr(OFS_WC_VAL, 32'h50);
    wc_ch[2] = 'h50;
    wr(OFS_BL_SEL, 32'h0);
    rd(OFS_BL_VAL, 32'h5);
    wr(OFS_WC_SEL, 32'h0);
    rd(OFS_WC_VAL, 32'hF00);
    beat('0, 1'b0, 1'b1);
    beat('1, 1'b0, 1'b1);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      beat({rnd, ~rnd, rnd ^ 32'h5A5A5A5A}, 1'b0, 1'b1);
    end
    idle();
    $display("test video path done");
    wr(OFS_BL_SEL, 32'h1);
    wr(OFS_BL_AUTO, {30'h0, MODE_ONCE});
    repeat (8) beat(one_ch(0, 88), 1'b1, 1'b0);
    idle();
    poll(OFS_BL_AUTO, {30'h0, MODE_OFF}, 20);
    rd(OFS_BL_VAL, 32'hFFFFFFE3);
    bl_ch[0] = -29;
    wr(OFS_BL_SEL, 32'h2);
    wr(OFS_BL_AUTO, {30'h0, MODE_CONT});
    repeat (6) beat(one_ch(1, 61), 1'b1, 1'b0);
    idle();
    rd(OFS_BL_AUTO, {30'h0, MODE_CONT});
    rd(OFS_BL_VAL, 32'hFFFFFFFE);
    rd(OFS_STATUS, 32'h0000000C);
    wr(OFS_BL_AUTO, {30'h0, MODE_OFF});
    $display("test black auto done");
    wr(OFS_BL_BAL, {30'h0, MODE_ONCE});
    poll(OFS_BL_BAL, {30'h0, MODE_OFF}, 40);
    rd(OFS_STATUS, 32'h00000018);
    wr(OFS_BL_SEL, 32'h5);
    rd(OFS_BL_VAL, 32'hFFFFFFE3);
    wr(OFS_BL_VAL, 32'h7);
    repeat (5) @(posedge clk_i);
    rd(OFS_BL_VAL, 32'h7);
    wr(OFS_BL_BAL, {30'h0, MODE_CONT});
    repeat (40) @(posedge clk_i);
    rd(OFS_BL_VAL, 32'hFFFFFFE3);
    rd(OFS_BL_BAL, {30'h0, MODE_CONT});
    rd(OFS_STATUS, 32'h0000001A);
    wr(OFS_BL_BAL, {30'h0, MODE_OFF});
    $display("test black balance done");
    wr(OFS_GAIN_SEL, 32'h2);
    wr(OFS_GAIN_VAL, 32'h105);
    rd(OFS_GAIN_VAL, 32'h105);
    rd(OFS_STATUS, 32'h00000010);
    wr(OFS_GAIN_BAL, {30'h0, MODE_ONCE});
    poll(OFS_GAIN_BAL, {30'h0, MODE_OFF}, 20);
    rd(OFS_GAIN_VAL, GAIN_RST);
    wr(OFS_GAIN_SEL, 32'h3);
    wr(OFS_GAIN_VAL, 32'hAB);
    repeat (10) @(posedge clk_i);
    rd(OFS_GAIN_VAL, 32'hAB);
    wr(OFS_GAIN_BAL, {30'h0, MODE_CONT});
    poll(OFS_GAIN_VAL, GAIN_RST, 200);
    rd(OFS_GAIN_BAL, {30'h0, MODE_CONT});
    rd(OFS_STATUS, 32'h00000019);
    ce_i <= 1'b0;
    wr(OFS_GAIN_VAL, 32'h55);
    ce_i <= 1'b1;
    rd(OFS_GAIN_VAL, GAIN_RST);
    repeat (3) @(posedge clk_i);
    chk("pending notes", '0, VW'(rd_q.size() + vid_q.size()));
    $display("test gain balance done");
    close_out();
  end
endmodule
